// >>> tone_qual_pkg.sv
// Shared constants and types for the DTMF tone qualifier.
package tone_qual_pkg;

  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int NUM_PARAMS = 10;

  // Times in microseconds and their sample counts.
  localparam int ON_FLOOR_US = 20000;
  localparam int ON_DEF_US = 40000;
  localparam int OFF_DEF_US = 40000;
  localparam int CYCLE_DEF_US = 93000;
  localparam int DROPOUT_DEF_US = 5000;
  localparam int ON_FLOOR_SAMPLES = ON_FLOOR_US * SAMPLE_RATE_HZ / 1000000;
  localparam int ON_DEF_SAMPLES =
    (ON_DEF_US - ON_FLOOR_US) * SAMPLE_RATE_HZ / 1000000;
  localparam int OFF_DEF_SAMPLES =
    (OFF_DEF_US - DROPOUT_DEF_US) * SAMPLE_RATE_HZ / 1000000;
  localparam int CYCLE_DEF_SAMPLES =
    (CYCLE_DEF_US - DROPOUT_DEF_US) * SAMPLE_RATE_HZ / 1000000;
  localparam int DROPOUT_DEF_SAMPLES = DROPOUT_DEF_US * SAMPLE_RATE_HZ / 1000000;

  // Register indices; the byte address is four times the index.
  localparam logic [13:0] IDX_LOW_DEV = 14'h0c94;
  localparam logic [13:0] IDX_POS_TWIST = 14'h0c95;
  localparam logic [13:0] IDX_OFF_TIME = 14'h0c96;
  localparam logic [13:0] IDX_NEG_TWIST = 14'h0d95;
  localparam logic [13:0] IDX_CYCLE_TIME = 14'h0d96;
  localparam logic [13:0] IDX_HIT_TIME = 14'h0e87;
  localparam logic [13:0] IDX_HIGH_DEV = 14'h0e94;
  localparam logic [13:0] IDX_SPEECH = 14'h0e95;
  localparam logic [13:0] IDX_ON_TIME = 14'h0e96;
  localparam logic [13:0] IDX_DROPOUT = 14'h0f96;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h1000;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h1001;
  localparam logic [13:0] IDX_LIVE = 14'h1002;

  // Slots of the parameter bank.
  localparam logic [3:0] SLOT_ON = 4'h0;
  localparam logic [3:0] SLOT_OFF = 4'h1;
  localparam logic [3:0] SLOT_CYCLE = 4'h2;
  localparam logic [3:0] SLOT_DROPOUT = 4'h3;
  localparam logic [3:0] SLOT_SPEECH = 4'h4;
  localparam logic [3:0] SLOT_LOW_DEV = 4'h5;
  localparam logic [3:0] SLOT_HIGH_DEV = 4'h6;
  localparam logic [3:0] SLOT_NEG_TWIST = 4'h7;
  localparam logic [3:0] SLOT_POS_TWIST = 4'h8;
  localparam logic [3:0] SLOT_HIT = 4'h9;

  localparam logic [15:0] SPEECH_OFF = 16'h7fff;
  localparam logic [15:0] PARAM_POS_MASK = 16'h7fff;
  localparam logic [15:0] DEV_DEF = 16'h0200;
  localparam logic [15:0] SPEECH_DEF = 16'h2000;
  localparam logic [15:0] NEG_TWIST_DEF = 16'h18ce;
  localparam logic [15:0] POS_TWIST_DEF = 16'h1b2d;
  localparam logic [15:0] HIT_DEF = 16'h0000;

  // Reset contents of the bank, slot 0 in the lowest word.
  localparam logic [NUM_PARAMS-1:0][15:0] PARAM_RESET = {
    HIT_DEF, POS_TWIST_DEF, NEG_TWIST_DEF, DEV_DEF, DEV_DEF, SPEECH_DEF,
    16'(DROPOUT_DEF_SAMPLES), 16'(CYCLE_DEF_SAMPLES),
    16'(OFF_DEF_SAMPLES), 16'(ON_DEF_SAMPLES)};

  // Interrupt status bits.
  localparam int EV_ACCEPT = 0;
  localparam int EV_REJECT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {Q_IDLE, Q_ON, Q_GAP, Q_OFF} qual_state_t;

endpackage

// >>> param_bank.sv
// Bank of qualifier parameter words with a registered read port.
module param_bank (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Write port
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_slot,
  input wire logic [15:0] i_wr_data,
  input wire logic [1:0] i_wr_bytes,
  // Read port
  input wire logic [3:0] i_rd_slot,
  output logic [15:0] o_rd_data,
  // All words for the qualifier
  output logic [tone_qual_pkg::NUM_PARAMS-1:0][15:0] o_words
);

  typedef struct packed {
    logic [tone_qual_pkg::NUM_PARAMS-1:0][15:0] words;
    logic [15:0] rd_data;
  } bank_t;

  bank_t bank_reg;
  bank_t bank_next;

  always_comb
  begin
    bank_next = bank_reg;
    if (i_wr_en && (int'(i_wr_slot) < tone_qual_pkg::NUM_PARAMS))
    begin
      if (i_wr_bytes[0])
        bank_next.words[i_wr_slot][7:0] = i_wr_data[7:0];
      if (i_wr_bytes[1])
        bank_next.words[i_wr_slot][15:8] = i_wr_data[15:8];
      // Words hold positive values only, so the sign bit never sets.
      bank_next.words[i_wr_slot] =
        bank_next.words[i_wr_slot] & tone_qual_pkg::PARAM_POS_MASK;
    end
    if (int'(i_rd_slot) < tone_qual_pkg::NUM_PARAMS)
      bank_next.rd_data = bank_reg.words[i_rd_slot];
    else
      bank_next.rd_data = 16'h0000;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      bank_reg.words <= tone_qual_pkg::PARAM_RESET;
      bank_reg.rd_data <= 16'h0000;
    end
    else
      bank_reg <= bank_next;
  end

  assign o_rd_data = bank_reg.rd_data;
  assign o_words = bank_reg.words;

endmodule

// >>> tone_qualifier.sv
// DTMF tone timing and spectral qualifier with an AXI4-Lite register slave.
// Summary of operation
// - On-time from detection to turn-off, floor 20 ms.
// - Off-time runs from turn-off until gain hit.
// - Cycle time from detection to next tone start.
// - Gaps within dropout time count as on-time; on_cnt here holds during a gap.
// - Parameter words are positive 16-bit values.
// - Reject tones while speech energy exceeds limit.
// - Full-scale speech limit disables the speech check.
// - Accepted tone raises the tone-detected flag.
// - Low-group deviation limited by low-group word.
// - High-group deviation limited by high-group word.
// - Negative twist limited; smaller word allows more.
// - Positive twist limited; smaller word allows more.
// - Energy hits tolerated only up to hit time.
//
// Our own choice: register access over AXI4-Lite.
module tone_qualifier (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Detector measurements, one set per sample strobe
  input wire logic i_sample_strobe,
  input wire logic i_energy_on,
  input wire logic [15:0] i_low_dev,
  input wire logic [15:0] i_high_dev,
  input wire logic [15:0] i_neg_twist_metric,
  input wire logic [15:0] i_pos_twist_metric,
  input wire logic [15:0] i_speech_energy,
  // AXI4-Lite write channels
  input wire logic [15:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read channels
  input wire logic [15:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Status
  output logic o_tone_detected_flag,
  output logic o_irq
);
  typedef struct packed {
    logic awready, wready;
    logic aw_full, w_full;
    logic [13:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rd_wait;
    logic [13:0] ar_idx;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] status, mask;
    logic irq;
    tone_qual_pkg::qual_state_t qst;
    logic [15:0] on_cnt, gap_cnt, off_cnt, hit_cnt, cyc_cnt;
    logic detected;
  } state_t;
  state_t s_reg, s_next;
  logic [tone_qual_pkg::NUM_PARAMS-1:0][15:0] words;
  logic [15:0] bank_rd_data;
  logic bank_wr_en;
  logic [3:0] bank_wr_slot;
  logic [3:0] bank_rd_slot;
  logic spectral_ok, tone_ok;
  logic [1:0] events;
  // Maps a register index to a bank slot; bit 4 flags a match.
  function automatic logic [4:0] slot_of(input logic [13:0] idx);
    case (idx)
      tone_qual_pkg::IDX_ON_TIME: slot_of = {1'b1, tone_qual_pkg::SLOT_ON};
      tone_qual_pkg::IDX_OFF_TIME: slot_of = {1'b1, tone_qual_pkg::SLOT_OFF};
      tone_qual_pkg::IDX_CYCLE_TIME:
        slot_of = {1'b1, tone_qual_pkg::SLOT_CYCLE};
      tone_qual_pkg::IDX_DROPOUT:
        slot_of = {1'b1, tone_qual_pkg::SLOT_DROPOUT};
      tone_qual_pkg::IDX_SPEECH: slot_of = {1'b1, tone_qual_pkg::SLOT_SPEECH};
      tone_qual_pkg::IDX_LOW_DEV:
        slot_of = {1'b1, tone_qual_pkg::SLOT_LOW_DEV};
      tone_qual_pkg::IDX_HIGH_DEV:
        slot_of = {1'b1, tone_qual_pkg::SLOT_HIGH_DEV};
      tone_qual_pkg::IDX_NEG_TWIST:
        slot_of = {1'b1, tone_qual_pkg::SLOT_NEG_TWIST};
      tone_qual_pkg::IDX_POS_TWIST:
        slot_of = {1'b1, tone_qual_pkg::SLOT_POS_TWIST};
      tone_qual_pkg::IDX_HIT_TIME: slot_of = {1'b1, tone_qual_pkg::SLOT_HIT};
      default: slot_of = 5'h00;
    endcase
  endfunction
  // Saturating sample counter step.
  function automatic logic [15:0] bump(input logic [15:0] v);
    bump = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction
  // True once a count has reached a limit plus an offset.
  function automatic logic reached(input logic [15:0] cnt,
                                   input logic [15:0] lim,
                                   input logic [15:0] extra);
    reached = {1'b0, cnt} >= ({1'b0, lim} + {1'b0, extra});
  endfunction
  param_bank u_bank (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_wr_en(bank_wr_en),
    .i_wr_slot(bank_wr_slot),
    .i_wr_data(s_reg.wdata[15:0]),
    .i_wr_bytes(s_reg.wstrb[1:0]),
    .i_rd_slot(bank_rd_slot),
    .o_rd_data(bank_rd_data),
    .o_words(words)
  );
  always_comb
  begin
    logic [4:0] wslot;
    logic [4:0] rslot;
    wslot = slot_of(s_reg.aw_idx);
    rslot = slot_of(i_araddr[15:2]);
    bank_wr_en = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid && wslot[4];
    bank_wr_slot = wslot[3:0];
    bank_rd_slot = rslot[3:0];
  end
  // Spectral checks that every sample of a tone must pass.
  always_comb
  begin
    spectral_ok =
      (i_low_dev <= words[tone_qual_pkg::SLOT_LOW_DEV]) &&
      (i_high_dev <= words[tone_qual_pkg::SLOT_HIGH_DEV]) &&
      (i_neg_twist_metric >= words[tone_qual_pkg::SLOT_NEG_TWIST]) &&
      (i_pos_twist_metric >= words[tone_qual_pkg::SLOT_POS_TWIST]) &&
      ((words[tone_qual_pkg::SLOT_SPEECH] == tone_qual_pkg::SPEECH_OFF) ||
       (i_speech_energy <= words[tone_qual_pkg::SLOT_SPEECH]));
    tone_ok = i_energy_on && spectral_ok;
  end
  always_comb
  begin
    logic [4:0] slot;
    slot = slot_of(s_reg.aw_idx);
    s_next = s_reg;
    events = 2'h0;
    // Write address and data are taken in either order.
    if (i_awvalid && s_reg.awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_idx = i_awaddr[15:2];
    end
    if (i_wvalid && s_reg.wready)
    begin
      s_next.w_full = 1'b1;
      s_next.wdata = i_wdata;
      s_next.wstrb = i_wstrb;
    end
    if (s_reg.bvalid && i_bready)
      s_next.bvalid = 1'b0;
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = tone_qual_pkg::RESP_OKAY;
      if (s_reg.aw_idx == tone_qual_pkg::IDX_IRQ_MASK)
      begin
        if (s_reg.wstrb[0])
          s_next.mask = s_reg.wdata[1:0];
      end
      else if (s_reg.aw_idx != tone_qual_pkg::IDX_IRQ_STATUS &&
               s_reg.aw_idx != tone_qual_pkg::IDX_LIVE && !slot[4])
        s_next.bresp = tone_qual_pkg::RESP_SLVERR;
    end
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready = !s_next.w_full && !s_next.bvalid;

    // Reads: bank data is registered once, then muxed into rdata.
    if (i_arvalid && s_reg.arready)
    begin
      s_next.arready = 1'b0;
      s_next.rd_wait = 1'b1;
      s_next.ar_idx = i_araddr[15:2];
    end
    if (s_reg.rd_wait)
    begin
      s_next.rd_wait = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = tone_qual_pkg::RESP_OKAY;
      slot = slot_of(s_reg.ar_idx);
      case (s_reg.ar_idx)
        tone_qual_pkg::IDX_IRQ_STATUS: s_next.rdata = {30'h0, s_reg.status};
        tone_qual_pkg::IDX_IRQ_MASK: s_next.rdata = {30'h0, s_reg.mask};
        tone_qual_pkg::IDX_LIVE:
          s_next.rdata = {28'h0, s_reg.qst, s_reg.detected, tone_ok};
        default:
        begin
          s_next.rdata = {16'h0, bank_rd_data};
          if (!slot[4])
          begin
            s_next.rdata = 32'h0;
            s_next.rresp = tone_qual_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    if (s_reg.rvalid && i_rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // Qualification, stepped once per sample.
    if (i_sample_strobe)
    begin
      s_next.cyc_cnt = bump(s_reg.cyc_cnt);
      case (s_reg.qst)
        tone_qual_pkg::Q_IDLE:
        begin
          // A new tone must also respect the cycle time of the last one.
          if (tone_ok && reached(s_reg.cyc_cnt,
                words[tone_qual_pkg::SLOT_CYCLE],
                words[tone_qual_pkg::SLOT_DROPOUT]))
          begin
            s_next.qst = tone_qual_pkg::Q_ON;
            s_next.on_cnt = 16'h0001;
            s_next.cyc_cnt = 16'h0001;
          end
        end
        tone_qual_pkg::Q_ON:
        begin
          if (tone_ok)
          begin
            s_next.on_cnt = bump(s_reg.on_cnt);
            if (!s_reg.detected && reached(s_next.on_cnt,
                  words[tone_qual_pkg::SLOT_ON],
                  16'(tone_qual_pkg::ON_FLOOR_SAMPLES)))
            begin
              s_next.detected = 1'b1;
              events[tone_qual_pkg::EV_ACCEPT] = 1'b1;
            end
          end
          else
          begin
            s_next.qst = tone_qual_pkg::Q_GAP;
            s_next.gap_cnt = 16'h0001;
          end
        end
        tone_qual_pkg::Q_GAP:
        begin
          if (tone_ok)
          begin
            // A short dropout is bridged and on-time resumes from its held count.
            s_next.qst = tone_qual_pkg::Q_ON;
            s_next.on_cnt = bump(s_reg.on_cnt);
          end
          else if (s_reg.gap_cnt >= words[tone_qual_pkg::SLOT_DROPOUT])
          begin
            s_next.qst = tone_qual_pkg::Q_OFF;
            s_next.off_cnt = 16'h0000;
            s_next.hit_cnt = 16'h0000;
            s_next.detected = 1'b0;
            events[tone_qual_pkg::EV_REJECT] = !s_reg.detected;
          end
          else
            s_next.gap_cnt = bump(s_reg.gap_cnt);
        end
        tone_qual_pkg::Q_OFF:
        begin
          s_next.off_cnt = bump(s_reg.off_cnt);
          if (i_energy_on)
          begin
            s_next.hit_cnt = bump(s_reg.hit_cnt);
            // A hit longer than tolerated restarts the off-time.
            if (s_reg.hit_cnt >= words[tone_qual_pkg::SLOT_HIT])
            begin
              s_next.off_cnt = 16'h0000;
              s_next.hit_cnt = 16'h0000;
            end
          end
          else
          begin
            s_next.hit_cnt = 16'h0000;
            if (s_reg.off_cnt >= words[tone_qual_pkg::SLOT_OFF])
              s_next.qst = tone_qual_pkg::Q_IDLE;
          end
        end
        default: s_next.qst = tone_qual_pkg::Q_IDLE;
      endcase
    end
    // Status bits: a new event wins over a write-one-to-clear.
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid &&
        s_reg.aw_idx == tone_qual_pkg::IDX_IRQ_STATUS && s_reg.wstrb[0])
      s_next.status = s_reg.status & ~s_reg.wdata[1:0];
    s_next.status = s_next.status | events;
    s_next.irq = |(s_next.status & s_next.mask);
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.qst <= tone_qual_pkg::Q_IDLE;
      s_reg.cyc_cnt <= 16'hffff;
    end
    else
      s_reg <= s_next;
  end
  assign o_awready = s_reg.awready;
  assign o_wready = s_reg.wready;
  assign o_bresp = s_reg.bresp;
  assign o_bvalid = s_reg.bvalid;
  assign o_arready = s_reg.arready;
  assign o_rdata = s_reg.rdata;
  assign o_rresp = s_reg.rresp;
  assign o_rvalid = s_reg.rvalid;
  assign o_tone_detected_flag = s_reg.detected;
  assign o_irq = s_reg.irq;
  a_flag_needs_tone: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $rose(s_reg.detected) |-> $past(tone_ok) && $past(i_sample_strobe)
      && $past(s_reg.qst) == tone_qual_pkg::Q_ON)
    else $error("Flag rose without a passing tone sample.");
  a_flag_on_time: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $rose(s_reg.detected) |-> reached(s_reg.on_cnt,
      words[tone_qual_pkg::SLOT_ON], 16'(tone_qual_pkg::ON_FLOOR_SAMPLES)))
    else $error("Flag rose before the minimum on-time.");
  a_speech_reject: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sample_strobe && s_reg.qst == tone_qual_pkg::Q_IDLE
      && words[tone_qual_pkg::SLOT_SPEECH] != tone_qual_pkg::SPEECH_OFF
      && i_speech_energy > words[tone_qual_pkg::SLOT_SPEECH]
      |=> s_reg.qst == tone_qual_pkg::Q_IDLE)
    else $error("Tone started despite speech energy.");
  a_twist_reject: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sample_strobe && s_reg.qst == tone_qual_pkg::Q_ON
      && (i_neg_twist_metric < words[tone_qual_pkg::SLOT_NEG_TWIST]
      || i_high_dev > words[tone_qual_pkg::SLOT_HIGH_DEV])
      |=> s_reg.qst == tone_qual_pkg::Q_GAP)
    else $error("Out-of-limit tone kept the on state.");
  a_gap_bridge: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sample_strobe && s_reg.qst == tone_qual_pkg::Q_GAP && tone_ok
      |=> s_reg.qst == tone_qual_pkg::Q_ON && $stable(s_reg.detected))
    else $error("Short dropout was not bridged.");
  a_hit_restart: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sample_strobe && s_reg.qst == tone_qual_pkg::Q_OFF && i_energy_on
      && s_reg.hit_cnt >= words[tone_qual_pkg::SLOT_HIT]
      |=> s_reg.off_cnt == 16'h0000 && s_reg.qst == tone_qual_pkg::Q_OFF)
    else $error("Long energy hit did not restart off-time.");
  a_param_positive: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    bank_wr_en |=> words[$past(bank_wr_slot)][15] == 1'b0)
    else $error("Parameter word took a negative value.");
  a_event_wins: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    events[tone_qual_pkg::EV_ACCEPT] |=> s_reg.status[tone_qual_pkg::EV_ACCEPT]
      && s_reg.irq == |(s_reg.status & s_reg.mask))
    else $error("Accept event lost or interrupt wrong.");
  a_write_answer: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_reg.aw_full && s_reg.w_full && !s_reg.bvalid
      |=> s_reg.bvalid && !s_reg.awready && !s_reg.wready)
    else $error("Write response missing.");
endmodule

// >>> tone_source.sv
// Line-side model: detector measurements paced by a sample strobe.
module tone_source (
  // Clock and commands from the bench
  input wire logic i_ref_clk,
  input wire logic i_tone,
  input wire logic [2:0] i_fault,
  // Detector measurements
  output logic o_strobe,
  output logic o_energy,
  output logic [15:0] o_low_dev,
  output logic [15:0] o_high_dev,
  output logic [15:0] o_neg,
  output logic [15:0] o_pos,
  output logic [15:0] o_speech
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg = 2'h0;
  logic ok;

  // One sample every four clocks keeps the run short; counts stay exact.
  initial
  begin
    o_strobe = 1'b0;
    o_energy = 1'b0;
  end

  always @(posedge i_ref_clk)
  begin
    ok = i_tone;
    div_reg <= div_reg + 2'h1;
    o_strobe <= (div_reg == 2'h3);
    o_energy <= i_tone;
    // Outside a tone the detector sees noise, so every metric fails.
    o_low_dev <= (ok && i_fault != 3'h1) ? 16'h0100 : 16'h0300;
    o_high_dev <= (ok && i_fault != 3'h2) ? 16'h0100 : 16'h0300;
    o_neg <= (ok && i_fault != 3'h3) ? 16'h2000 : 16'h1000;
    o_pos <= (ok && i_fault != 3'h4) ? 16'h2000 : 16'h1000;
    o_speech <= (ok && i_fault != 3'h5) ? 16'h1000 : 16'h3000;
  end
endmodule

// >>> test_dtmf_tone_qualifier.sv
// Self-checking bench for the DTMF tone qualifier.
module test_dtmf_tone_qualifier;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tone = 1'b0;
  logic [2:0] fault = 3'h0;
  logic strobe, energy;
  logic [15:0] lowd, highd, negm, posm, speech;
  logic [15:0] awaddr = 16'h0;
  logic [15:0] araddr = 16'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, flag, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int err_total = 0;
  int compares = 0;
  int first;

  always #50 clk = ~clk;

  tone_source tone_source_inst (.i_ref_clk(clk), .i_tone(tone),
    .i_fault(fault), .o_strobe(strobe), .o_energy(energy),
    .o_low_dev(lowd), .o_high_dev(highd), .o_neg(negm), .o_pos(posm),
    .o_speech(speech));

  tone_qualifier tone_qualifier_inst (.i_ref_clk(clk), .i_srst(srst),
    .i_sample_strobe(strobe), .i_energy_on(energy), .i_low_dev(lowd),
    .i_high_dev(highd), .i_neg_twist_metric(negm),
    .i_pos_twist_metric(posm), .i_speech_energy(speech),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready),
    .o_tone_detected_flag(flag), .o_irq(irq));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang();
    err_total++;
    give_verdict();
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, acted on at the next rise.
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    logic a, w, b;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bready && bvalid;
      rs = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b)
      begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdr(input logic [13:0] idx);
    logic a, r;
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk);
      a = arvalid && arready;
      r = rready && rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (r)
      begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // Tone of n1 samples, gap of g, then n2 more; first counts energised
  // samples up to the flag. Counting starts at once so none is missed.
  task automatic run(input int n1, input int g, input int n2,
                     input logic [2:0] f);
    int s, n, p;
    first = 0;
    s = 0;
    p = 0;
    @(posedge clk);
    fault <= f;
    tone <= 1'b1;
    for (n = 0; n < 4000 && s < n1 + g + n2 + 150; n++)
    begin
      @(negedge clk);
      if (flag === 1'b1 && first == 0) first = p;
      if (strobe === 1'b1) s++;
      if (strobe === 1'b1 && energy === 1'b1) p++;
      @(posedge clk);
      tone <= (s < n1) || (s >= n1 + g && s < n1 + g + n2);
    end
    if (n == 4000) hang();
    check(32'(flag), 32'h0);
  endtask

  task automatic t_reset();
    logic [13:0] idx [10] = '{tone_qual_pkg::IDX_ON_TIME,
      tone_qual_pkg::IDX_OFF_TIME, tone_qual_pkg::IDX_CYCLE_TIME,
      tone_qual_pkg::IDX_DROPOUT, tone_qual_pkg::IDX_SPEECH,
      tone_qual_pkg::IDX_LOW_DEV, tone_qual_pkg::IDX_HIGH_DEV,
      tone_qual_pkg::IDX_NEG_TWIST, tone_qual_pkg::IDX_POS_TWIST,
      tone_qual_pkg::IDX_HIT_TIME};
    logic [15:0] dv [10] = '{16'h00a0, 16'h0118, 16'h02c0, 16'h0028,
      16'h2000, 16'h0200, 16'h0200, 16'h18ce, 16'h1b2d, 16'h0000};
    for (int i = 0; i < 10; i++)
    begin
      rdr(idx[i]);
      check(rd, {16'h0, dv[i]});
    end
    rdr(14'h0100);
    check({rd, 30'h0, rs}, {32'h0, 30'h0, tone_qual_pkg::RESP_SLVERR});
    wr(14'h0100, 32'h0);
    check(rs, tone_qual_pkg::RESP_SLVERR);
    rdr(tone_qual_pkg::IDX_LIVE);
    check(rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_setup();
    wr(tone_qual_pkg::IDX_LOW_DEV, 32'hffff_ffff);
    check(rs, tone_qual_pkg::RESP_OKAY);
    rdr(tone_qual_pkg::IDX_LOW_DEV);
    check(rd, 32'h0000_7fff);
    wr(tone_qual_pkg::IDX_LOW_DEV, 32'h0200);
    wr(tone_qual_pkg::IDX_ON_TIME, 32'h0);
    wr(tone_qual_pkg::IDX_OFF_TIME, 32'h0);
    wr(tone_qual_pkg::IDX_CYCLE_TIME, 32'h0);
    rdr(tone_qual_pkg::IDX_DROPOUT);
    wr(tone_qual_pkg::IDX_DROPOUT, rd - 32'h24);
    rdr(tone_qual_pkg::IDX_DROPOUT);
    check(rd, 32'h4);
    wr(tone_qual_pkg::IDX_IRQ_MASK, 32'h1);
    $display("test setup done");
  endtask

  task automatic t_accept();
    run(170, 0, 0, 3'h0);
    check(first, 160);
    rdr(tone_qual_pkg::IDX_IRQ_STATUS);
    check({rd, 31'h0, irq}, {32'h1, 32'h1});
    wr(tone_qual_pkg::IDX_IRQ_STATUS, 32'h1);
    rdr(tone_qual_pkg::IDX_IRQ_STATUS);
    check({rd, 31'h0, irq}, 64'h0);
    $display("test accept done");
  endtask

  task automatic t_faults();
    for (int f = 1; f < 6; f++)
    begin
      run(170, 0, 0, 3'(f));
      check(first, 0);
    end
    run(40, 0, 0, 3'h0);
    check(first, 0);
    // A rejected tone sets the masked status bit, so no interrupt.
    rdr(tone_qual_pkg::IDX_IRQ_STATUS);
    check({rd, 31'h0, irq}, {32'h2, 32'h0});
    wr(tone_qual_pkg::IDX_SPEECH, 32'h7fff);
    run(170, 0, 0, 3'h5);
    check(first, 160);
    wr(tone_qual_pkg::IDX_SPEECH, 32'h2000);
    wr(tone_qual_pkg::IDX_IRQ_STATUS, 32'h3);
    $display("test faults done");
  endtask

  task automatic t_timing();
    run(100, 3, 100, 3'h0);
    check(32'(first != 0), 32'h1);
    run(100, 10, 100, 3'h0);
    check(first, 0);
    wr(tone_qual_pkg::IDX_CYCLE_TIME, 32'd100);
    run(40, 10, 170, 3'h0);
    check(first, 0);
    wr(tone_qual_pkg::IDX_CYCLE_TIME, 32'h0);
    wr(tone_qual_pkg::IDX_OFF_TIME, 32'd100);
    run(40, 10, 170, 3'h0);
    check(first, 0);
    wr(tone_qual_pkg::IDX_OFF_TIME, 32'h0);
    run(40, 10, 170, 3'h0);
    check(32'(first != 0), 32'h1);
    $display("test timing done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_setup();
    t_accept();
    t_faults();
    t_timing();
    give_verdict();
  end
endmodule
